/* File: bench/host_model.sv */
// Purpose: remote host side of the command port, issuing commands and queries
// Assumes: design takes a command at the rising edge it is presented on
// Notes: every request is held for exactly one cycle, then the port goes idle
`timescale 1ns/1ps
module host_model
  import status_pkg::*;
(
  // clock
  input wire logic clock_in,
  // command port
  output cmd_req_t req_out,
  input wire cmd_rsp_t rsp_in
);
  initial req_out = '0;

  // ==========================================================
  // command and query tasks
  task automatic send(input cmd_t c, input group_sel_t g, input reg_sel_t r,
                      input logic [15:0] d);
    @(posedge clock_in);
    #1 req_out = '{cmd: c, group: g, regsel: r, data: d};
    @(posedge clock_in);
    #1 req_out = '0;
  endtask : send

  // enable value is one number: the summed weights of the wanted bits
  task automatic write_enable(input group_sel_t g, input logic [15:0] weights);
    send(CMD_WRITE, g, REG_ENABLE, weights);
  endtask : write_enable

  task automatic query(input group_sel_t g, input reg_sel_t r, output logic [15:0] d,
                       output logic ok);
    send(CMD_READ, g, r, 16'h0000);
    ok = 1'b0;
    d = 16'h0000;
    for (int i = 0; i < 3 && !ok; i++) begin
      if (rsp_in.valid === 1'b1) begin
        ok = 1'b1;
        d = rsp_in.data;
      end else begin
        @(posedge clock_in);
        #1;
      end
    end
  endtask : query
endmodule : host_model

/* File: bench/status_summary_registers_bench.sv */
// Purpose: self-checking bench for the status summary hierarchy
// Assumes: status inputs reach the summary within six cycles
// Notes: groups 0..3 feed summary bits 7, 5, 3 and 1
`timescale 1ns/1ps
module status_summary_registers_bench
  import status_pkg::*;
;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic restart_in = 1'b0;
  logic message_in = 1'b0;
  logic error_in = 1'b0;
  logic [15:0] cond [4] = '{default: 16'h0000};
  cmd_req_t req;
  cmd_rsp_t rsp;
  logic [7:0] summary_out;
  logic [7:0] summary_enable_out;
  logic power_clear_out;
  int n_errors = 0;
  int n_tests = 0;
  int bit_pos [4] = '{7, 5, 3, 1};

  always #2.5 clock_in = ~clock_in;

  status_summary_registers u_status_summary_registers (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .restart_in(restart_in),
    .operation_cond_in(cond[0]), .standard_cond_in(cond[1]),
    .questionable_cond_in(cond[2]), .alarm_cond_in(cond[3]),
    .message_available_in(message_in), .error_queue_nonempty_in(error_in),
    .req_in(req), .rsp_out(rsp), .summary_out(summary_out),
    .summary_enable_out(summary_enable_out), .power_clear_out(power_clear_out)
  );

  host_model u_host_model (.clock_in(clock_in), .req_out(req), .rsp_in(rsp));

  // ==========================================================
  // helpers
  task automatic end_of_test();
    if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic rd(input string what, input group_sel_t g, input reg_sel_t r,
                    input logic [15:0] exp);
    logic [15:0] d;
    logic ok;
    u_host_model.query(g, r, d, ok);
    if (!ok) begin
      n_errors++;
      end_of_test();
    end else begin
      check(what, d, exp);
    end
  endtask : rd

  task automatic settle();
    repeat (6) @(posedge clock_in);
    #1;
  endtask : settle

  task automatic pulse_cond(input int g, input logic [15:0] v);
    cond[g] = v;
    settle();
    cond[g] = 16'h0000;
    settle();
  endtask : pulse_cond

  // ==========================================================
  // scenarios
  task automatic t_reset();
    check("summary", {8'h00, summary_out}, 16'h0000);
    check("summary enable", {8'h00, summary_enable_out}, 16'h0000);
    check("power clear", {15'h0000, power_clear_out}, 16'h0001);
  endtask : t_reset

  task automatic t_condition();
    cond[2] = 16'h8005;
    settle();
    rd("ques cond", SEL_QUESTIONABLE, REG_CONDITION, 16'h8005);
    rd("ques cond again", SEL_QUESTIONABLE, REG_CONDITION, 16'h8005);
    cond[2] = 16'h0000;
    settle();
    rd("ques cond live", SEL_QUESTIONABLE, REG_CONDITION, 16'h0000);
    rd("ques event", SEL_QUESTIONABLE, REG_EVENT, 16'h8005);
    rd("ques event cleared", SEL_QUESTIONABLE, REG_EVENT, 16'h0000);
  endtask : t_condition

  task automatic t_latch();
    pulse_cond(0, 16'h0001);
    pulse_cond(0, 16'h0001);
    u_host_model.send(CMD_WRITE, SEL_OPERATION, REG_EVENT, 16'h0000);
    rd("op event held", SEL_OPERATION, REG_EVENT, 16'h0001);
    rd("op event read clear", SEL_OPERATION, REG_EVENT, 16'h0000);
  endtask : t_latch

  task automatic t_summary();
    logic [7:0] w;
    u_host_model.write_enable(SEL_SUMMARY, 16'h00ff);
    rd("summary enable", SEL_SUMMARY, REG_ENABLE, 16'h00bf);
    for (int g = 0; g < 4; g++) begin
      w = 8'h01 << bit_pos[g];
      pulse_cond(g, 16'h0010);
      check("gated summary", {8'h00, summary_out}, 16'h0000);
      u_host_model.write_enable(group_sel_t'(g), 16'h0010);
      settle();
      check("group summary", {8'h00, summary_out}, {8'h00, w | 8'h40});
      rd("group enable", group_sel_t'(g), REG_ENABLE, 16'h0010);
      rd("group event", group_sel_t'(g), REG_EVENT, 16'h0010);
      settle();
      check("summary after read", {8'h00, summary_out}, 16'h0000);
    end
  endtask : t_summary

  task automatic t_levels();
    message_in = 1'b1;
    settle();
    rd("message bit", SEL_SUMMARY, REG_CONDITION, 16'h0050);
    message_in = 1'b0;
    error_in = 1'b1;
    settle();
    check("error bit", {8'h00, summary_out}, 16'h0044);
    error_in = 1'b0;
    settle();
    check("error emptied", {8'h00, summary_out}, 16'h0000);
  endtask : t_levels

  task automatic t_clear();
    pulse_cond(1, 16'h0010);
    check("std summary", {8'h00, summary_out}, 16'h0060);
    u_host_model.send(CMD_CLEAR_STATUS, SEL_OPERATION, REG_CONDITION, 16'h0000);
    settle();
    check("cleared summary", {8'h00, summary_out}, 16'h0000);
    rd("cleared event", SEL_STANDARD, REG_EVENT, 16'h0000);
    u_host_model.send(CMD_PRESET, SEL_OPERATION, REG_CONDITION, 16'h0000);
    for (int g = 0; g < 4; g++) begin
      rd("preset enable", group_sel_t'(g), REG_ENABLE, 16'h0000);
    end
    u_host_model.write_enable(SEL_SUMMARY, 16'h0000);
    rd("zero summary enable", SEL_SUMMARY, REG_ENABLE, 16'h0000);
  endtask : t_clear

  task automatic t_power(input logic flag, input logic [15:0] exp);
    u_host_model.write_enable(SEL_SUMMARY, 16'h0081);
    u_host_model.send(CMD_SET_POWER_CLEAR, SEL_SUMMARY, REG_CONDITION, {15'h0000, flag});
    check("flag", {15'h0000, power_clear_out}, {15'h0000, flag});
    @(posedge clock_in);
    #1 restart_in = 1'b1;
    @(posedge clock_in);
    #1 restart_in = 1'b0;
    rd("enable after restart", SEL_SUMMARY, REG_ENABLE, exp);
  endtask : t_power

  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (10) @(posedge clock_in);
    #1 rst_n_in = 1'b1;
    t_reset();
    t_condition();
    t_latch();
    t_summary();
    t_levels();
    t_clear();
    t_power(1'b0, 16'h0081);
    t_power(1'b1, 16'h0000);
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge clock_in);
    n_errors++;
    end_of_test();
  end
endmodule : status_summary_registers_bench

/* File: rtl/status_group.sv */
// Purpose: one condition, event and enable register group
// Assumes: condition bits arrive on the same clock
// Notes: a latched event stays until read or clear
`timescale 1ns/1ps
module status_group
  import status_pkg::*;
#(
  parameter int WIDTH = GROUP_WIDTH
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // live status
  input wire logic [WIDTH-1:0] condition_in,
  // control
  input wire logic clear_event_in,
  input wire logic enable_write_in,
  input wire logic enable_clear_in,
  input wire logic [WIDTH-1:0] enable_data_in,
  // state
  output logic [WIDTH-1:0] event_out,
  output logic [WIDTH-1:0] enable_out,
  output logic summary_out
);

  if (WIDTH < 1 || WIDTH > 16) begin : g_width_check
    $error("status_group width out of range");
  end

  logic [WIDTH-1:0] condition_last;
  logic [WIDTH-1:0] rising;
  logic [WIDTH-1:0] next_event;

  assign rising = condition_in & ~condition_last;
  // new events win over a clear in the same cycle; held bits ignore repeats
  assign next_event = (clear_event_in ? '0 : event_out) | rising;
  assign summary_out = |(event_out & enable_out);

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      condition_last <= '0;
      event_out <= '0;
    end else begin
      condition_last <= condition_in;
      event_out <= next_event;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      enable_out <= GROUP_ENABLE_RESET[WIDTH-1:0];
    end else if (enable_clear_in) begin
      enable_out <= '0;
    end else if (enable_write_in) begin
      enable_out <= enable_data_in;
    end
  end

endmodule : status_group

/* File: rtl/status_pkg.sv */
// Purpose: shared constants and carriers for the status reporting hierarchy
// Assumes: one clock, registers reached through a command port driven by the parser
// Notes: group selects and summary bit positions live here
package status_pkg;

  localparam int GROUP_WIDTH = 16;
  localparam int SUMMARY_WIDTH = 8;

  // summary byte bit positions
  localparam int BIT_UNUSED = 0;
  localparam int BIT_ALARM = 1;
  localparam int BIT_ERROR_QUEUE = 2;
  localparam int BIT_QUESTIONABLE = 3;
  localparam int BIT_MESSAGE = 4;
  localparam int BIT_STANDARD = 5;
  localparam int BIT_MASTER = 6;
  localparam int BIT_OPERATION = 7;

  localparam logic [7:0] SUMMARY_ENABLE_RESET = 8'h00;
  localparam logic [15:0] GROUP_ENABLE_RESET = 16'h0000;
  localparam logic POWER_CLEAR_RESET = 1'b1;

  // register group selects on the command port
  typedef enum logic [2:0] {
    SEL_OPERATION = 3'h0,
    SEL_STANDARD = 3'h1,
    SEL_QUESTIONABLE = 3'h2,
    SEL_ALARM = 3'h3,
    SEL_SUMMARY = 3'h4
  } group_sel_t;

  // which register of a group
  typedef enum logic [1:0] {
    REG_CONDITION = 2'h0,
    REG_EVENT = 2'h1,
    REG_ENABLE = 2'h2
  } reg_sel_t;

  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_READ = 3'h1,
    CMD_WRITE = 3'h2,
    CMD_CLEAR_STATUS = 3'h3,
    CMD_PRESET = 3'h4,
    CMD_SET_POWER_CLEAR = 3'h5
  } cmd_t;

  typedef struct packed {
    cmd_t cmd;
    group_sel_t group;
    reg_sel_t regsel;
    logic [15:0] data;
  } cmd_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } cmd_rsp_t;

endpackage : status_pkg

/* File: rtl/status_summary_registers.sv */
// Purpose: status summary hierarchy with command port for the parser
// Assumes: command parser on clock_in; live status inputs from other clocks/pins
// Notes: answers are binary; decimal text conversion is the parser's job
`timescale 1ns/1ps
module status_summary_registers
  import status_pkg::*;
#(
  parameter int WIDTH = GROUP_WIDTH
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // restart; keeps stored settings unless power-on-clear is set, which clears the summary enable
  input wire logic restart_in,
  // live status, asynchronous to clock_in
  input wire logic [WIDTH-1:0] operation_cond_in,
  input wire logic [WIDTH-1:0] standard_cond_in,
  input wire logic [WIDTH-1:0] questionable_cond_in,
  input wire logic [WIDTH-1:0] alarm_cond_in,
  input wire logic message_available_in,
  input wire logic error_queue_nonempty_in,
  // command port
  input wire cmd_req_t req_in,
  output cmd_rsp_t rsp_out,
  // state
  output logic [7:0] summary_out,
  output logic [7:0] summary_enable_out,
  output logic power_clear_out
);

  if (WIDTH < 1 || WIDTH > 16) begin : g_width_check
    $error("group width out of range");
  end

  // ==========================================================
  // input synchronisers
  localparam int SYNC_W = 4 * WIDTH + 2;
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic [WIDTH-1:0] cond_op;
  logic [WIDTH-1:0] cond_std;
  logic [WIDTH-1:0] cond_ques;
  logic [WIDTH-1:0] cond_alarm;
  logic msg_avail;
  logic err_nonempty;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {operation_cond_in, standard_cond_in, questionable_cond_in,
                 alarm_cond_in, message_available_in, error_queue_nonempty_in};
      sync_b <= sync_a;
    end
  end

  // live status follows inputs, nothing else writes it
  assign {cond_op, cond_std, cond_ques, cond_alarm, msg_avail, err_nonempty} = sync_b;

  // ==========================================================
  // command decode
  wire is_read = (req_in.cmd == CMD_READ);
  wire is_write = (req_in.cmd == CMD_WRITE);
  wire is_cls = (req_in.cmd == CMD_CLEAR_STATUS);
  wire is_preset = (req_in.cmd == CMD_PRESET);
  wire is_psc = (req_in.cmd == CMD_SET_POWER_CLEAR);
  wire read_event = is_read && (req_in.regsel == REG_EVENT);
  wire write_enable = is_write && (req_in.regsel == REG_ENABLE);

  function automatic logic sel(input group_sel_t g, input group_sel_t want);
    sel = (g == want);
  endfunction : sel

  // reading a group's event register clears it; event register not writable
  wire clr_op = is_cls || (read_event && sel(req_in.group, SEL_OPERATION));
  wire clr_std = is_cls || (read_event && sel(req_in.group, SEL_STANDARD));
  wire clr_ques = is_cls || (read_event && sel(req_in.group, SEL_QUESTIONABLE));
  wire clr_alarm = is_cls || (read_event && sel(req_in.group, SEL_ALARM));

  // ==========================================================
  // register groups
  logic [WIDTH-1:0] ev_op, ev_std, ev_ques, ev_alarm;
  logic [WIDTH-1:0] en_op, en_std, en_ques, en_alarm;
  logic sum_op, sum_std, sum_ques, sum_alarm;

  status_group #(.WIDTH(WIDTH)) u_operation (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .condition_in(cond_op),
    .clear_event_in(clr_op), .enable_clear_in(is_preset),
    .enable_write_in(write_enable && sel(req_in.group, SEL_OPERATION)),
    .enable_data_in(req_in.data[WIDTH-1:0]),
    .event_out(ev_op), .enable_out(en_op), .summary_out(sum_op)
  );
  status_group #(.WIDTH(WIDTH)) u_standard (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .condition_in(cond_std),
    .clear_event_in(clr_std), .enable_clear_in(is_preset),
    .enable_write_in(write_enable && sel(req_in.group, SEL_STANDARD)),
    .enable_data_in(req_in.data[WIDTH-1:0]),
    .event_out(ev_std), .enable_out(en_std), .summary_out(sum_std)
  );
  status_group #(.WIDTH(WIDTH)) u_questionable (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .condition_in(cond_ques),
    .clear_event_in(clr_ques), .enable_clear_in(is_preset),
    .enable_write_in(write_enable && sel(req_in.group, SEL_QUESTIONABLE)),
    .enable_data_in(req_in.data[WIDTH-1:0]),
    .event_out(ev_ques), .enable_out(en_ques), .summary_out(sum_ques)
  );
  status_group #(.WIDTH(WIDTH)) u_alarm (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .condition_in(cond_alarm),
    .clear_event_in(clr_alarm), .enable_clear_in(is_preset),
    .enable_write_in(write_enable && sel(req_in.group, SEL_ALARM)),
    .enable_data_in(req_in.data[WIDTH-1:0]),
    .event_out(ev_alarm), .enable_out(en_alarm), .summary_out(sum_alarm)
  );

  // ==========================================================
  // summary byte
  logic [7:0] next_summary;
  always_comb begin
    next_summary = 8'h00;
    // group events cleared by a read drop their summary bit one clock after the event register clears
    next_summary[BIT_OPERATION] = sum_op;
    next_summary[BIT_STANDARD] = sum_std;
    next_summary[BIT_MESSAGE] = msg_avail;
    next_summary[BIT_QUESTIONABLE] = sum_ques;
    next_summary[BIT_ERROR_QUEUE] = err_nonempty;
    next_summary[BIT_ALARM] = sum_alarm;
    next_summary[BIT_UNUSED] = 1'b0;
    // master bit: summary of the other enabled bits
    next_summary[BIT_MASTER] = |(next_summary & summary_enable_out
                                 & ~(8'h01 << BIT_MASTER));
  end

  // summary follows its sources; a clear status forces one cleared cycle
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      summary_out <= 8'h00;
    end else if (is_cls) begin
      summary_out <= 8'h00;
    end else begin
      summary_out <= next_summary;
    end
  end

  // summary enable: preserved across restart unless power-on-clear set
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      summary_enable_out <= SUMMARY_ENABLE_RESET;
    end else if (restart_in && power_clear_out) begin
      summary_enable_out <= 8'h00;
    end else if (write_enable && sel(req_in.group, SEL_SUMMARY)) begin
      // zero clears all bits; bit 6 is not maskable
      summary_enable_out <= req_in.data[7:0] & 8'hbf;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      power_clear_out <= POWER_CLEAR_RESET;
    end else if (is_psc) begin
      power_clear_out <= req_in.data[0];
    end
  end

  // ==========================================================
  // read answers, binary sum of weights
  function automatic logic [15:0] pick(input reg_sel_t r, input logic [WIDTH-1:0] c,
                                       input logic [WIDTH-1:0] e, input logic [WIDTH-1:0] n);
    logic [WIDTH-1:0] v;
    v = (r == REG_CONDITION) ? c : (r == REG_EVENT) ? e : n;
    pick = 16'(v);
  endfunction : pick

  logic [15:0] read_value;
  always_comb begin
    unique case (req_in.group)
      SEL_OPERATION: read_value = pick(req_in.regsel, cond_op, ev_op, en_op);
      SEL_STANDARD: read_value = pick(req_in.regsel, cond_std, ev_std, en_std);
      SEL_QUESTIONABLE: read_value = pick(req_in.regsel, cond_ques, ev_ques, en_ques);
      SEL_ALARM: read_value = pick(req_in.regsel, cond_alarm, ev_alarm, en_alarm);
      SEL_SUMMARY: read_value = (req_in.regsel == REG_ENABLE) ?
                                {8'h00, summary_enable_out} : {8'h00, summary_out};
      default: read_value = 16'h0000;
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rsp_out <= '0;
    end else begin
      rsp_out.valid <= is_read;
      rsp_out.data <= is_read ? read_value : 16'h0000;
    end
  end

  // ==========================================================
  // assertions
  wire [WIDTH-1:0] wr_data = req_in.data[WIDTH-1:0];

  sequence s_read_taken;
    is_read;
  endsequence

  sequence s_answer_pulse;
    rsp_out.valid ##1 (!rsp_out.valid || $past(is_read));
  endsequence

  a_bit0_zero: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    summary_out[BIT_UNUSED] == 1'b0) else $error("unused summary bit set");

  a_cls_clears: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    is_cls |=> summary_out == 8'h00) else $error("clear status left summary");

  a_read_answer: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    is_read |=> rsp_out.valid && rsp_out.data == $past(read_value))
    else $error("read answer wrong");

  a_read_walk: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    s_read_taken |=> s_answer_pulse) else $error("read answer not one cycle");

  a_idle_data: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !rsp_out.valid |-> rsp_out.data == 16'h0000) else $error("answer data without valid");

  a_cond_read: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    is_read && req_in.regsel == REG_CONDITION && sel(req_in.group, SEL_QUESTIONABLE)
    |=> rsp_out.data[WIDTH-1:0] == $past(cond_ques)) else $error("condition read wrong");

  a_event_cleared: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    clr_op && !(|(cond_op & ~u_operation.condition_last)) |=> ev_op == '0)
    else $error("event not cleared");

  a_event_holds: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !clr_op |=> (ev_op & $past(ev_op)) == $past(ev_op))
    else $error("event bit lost");

  a_preset_enables: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    is_preset |=> en_op == '0 && en_std == '0 && en_ques == '0 && en_alarm == '0)
    else $error("preset left enable");

  a_enable_write: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    write_enable && sel(req_in.group, SEL_STANDARD) |=> en_std == $past(wr_data))
    else $error("group enable not written");

  a_error_bit: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !is_cls |=> summary_out[BIT_ERROR_QUEUE] == $past(err_nonempty))
    else $error("error queue bit wrong");

  a_message_bit: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !is_cls |=> summary_out[BIT_MESSAGE] == $past(msg_avail))
    else $error("message bit wrong");

  a_op_summary: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !is_cls |=> summary_out[BIT_OPERATION] == |($past(ev_op) & $past(en_op)))
    else $error("operation summary wrong");

  a_std_summary: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !is_cls |=> summary_out[BIT_STANDARD] == |($past(ev_std) & $past(en_std)))
    else $error("standard summary wrong");

  a_ques_summary: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !is_cls |=> summary_out[BIT_QUESTIONABLE] == |($past(ev_ques) & $past(en_ques)))
    else $error("questionable summary wrong");

  a_alarm_summary: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !is_cls |=> summary_out[BIT_ALARM] == |($past(ev_alarm) & $past(en_alarm)))
    else $error("alarm summary wrong");

  a_master_bit: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    summary_out[BIT_MASTER] == |(summary_out & $past(summary_enable_out) & 8'hbf))
    else $error("master summary wrong");

  a_enable_zero: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    write_enable && sel(req_in.group, SEL_SUMMARY) && req_in.data[7:0] == 8'h00
    && !restart_in |=> summary_enable_out == 8'h00)
    else $error("summary enable not cleared");

  a_restart_clear: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    restart_in && power_clear_out |=> summary_enable_out == 8'h00)
    else $error("restart kept enable");

  a_restart_keep: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    restart_in && !power_clear_out && !write_enable |=> $stable(summary_enable_out))
    else $error("restart lost enable");

  a_flag_set: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    is_psc && req_in.data[0] |=> power_clear_out) else $error("power clear flag not set");

  a_flag_clear: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    is_psc && !req_in.data[0] |=> !power_clear_out) else $error("power clear flag not cleared");

endmodule : status_summary_registers
